/* File: design/pfs_pkg.sv */
// ==========================================================
// pad function select: shared constants
package pfs_pkg;
  // sizes
  localparam int NUM_PADS = 8;
  localparam int NUM_ALT = 5;
  localparam int SEL_W = 3;
  localparam int CFG_W = 8;
  localparam int IDX_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TRACE_W = 14;
  localparam int TRACE_LOW_W = 8;
  // pad config register fields
  localparam int F_SEL_LO = 0;
  localparam int F_IBE = 3;
  localparam int F_OBE = 4;
  localparam int F_PUE = 5;
  localparam int F_SLOW = 6;
  localparam int F_NMI = 7;
  // function select codes
  localparam logic [SEL_W-1:0] SEL_FIRST = 3'h0;
  localparam logic [SEL_W-1:0] SEL_JTAG = 3'h2;
  localparam logic [SEL_W-1:0] SEL_FIFTH = 3'h4;
  // reset values: pads 0..3 carry the test port, the rest general-purpose and tristate
  localparam logic [CFG_W-1:0] CFG_RST_GPIO = 8'h00;
  localparam logic [CFG_W-1:0] CFG_RST_TDI = 8'h2A;
  localparam logic [CFG_W-1:0] CFG_RST_TDO = 8'h12;
  localparam logic [CFG_W-1:0] CFG_RST_TCK = 8'h0A;
  localparam logic [CFG_W-1:0] CFG_RST_TMS = 8'h0A;
  localparam logic [NUM_PADS-1:0][CFG_W-1:0] CFG_RST = '{
    CFG_RST_GPIO, CFG_RST_GPIO, CFG_RST_GPIO, CFG_RST_GPIO,
    CFG_RST_TMS, CFG_RST_TCK, CFG_RST_TDO, CFG_RST_TDI};
  localparam logic [SEL_W-1:0] INSEL_RST = 3'h0;
  // pad drive types, index 7 leftmost
  localparam logic [1:0] PT_SLOW = 2'h0;
  localparam logic [1:0] PT_MED = 2'h1;
  localparam logic [1:0] PT_FAST = 2'h2;
  localparam logic [NUM_PADS-1:0][1:0] PAD_TYPE = '{
    PT_MED, PT_SLOW, PT_SLOW, PT_SLOW, PT_MED, PT_MED, PT_FAST, PT_MED};
  // pads shared with the slow crystal oscillator
  localparam logic [NUM_PADS-1:0] XTAL_MASK = 8'h30;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PCR_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PCR_END = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_INSEL = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
  localparam int ADDR_IDX_LO = 2;
  // status bits
  localparam int S_MEMORY_BUILTIN_SELF_TEST = 0;
  localparam int S_XTAL = 1;
  localparam int S_TRACE_CLOCK_OUT = 2;
  localparam int S_PSTAT = 3;
  localparam int S_FPM = 4;
  localparam int STATUS_W = 5;
  // trace pad positions
  localparam int TR_HI_LO = 8;
  localparam int TR_HI_W = 4;
  localparam int TR_TRACE_MESSAGE_START_END = 12;
  localparam int TR_TRACE_CLOCK_OUT = 13;
  // bus handshake states
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_ACK = 1'b1
  } pfs_bus_st_t;
endpackage : pfs_pkg

/* File: design/pfs_pad_slice.sv */
`timescale 1ns/1ps
// ==========================================================
// one pad: output mux, input gating, pull and slew
module pfs_pad_slice #(
  parameter logic [1:0] PAD_KIND = 2'h0
) (
  // configuration
  input wire logic [pfs_pkg::CFG_W-1:0] cfg,
  input wire logic xtal_on,
  // peripheral side
  input wire logic [pfs_pkg::NUM_ALT-1:0] alt_out,
  input wire logic [pfs_pkg::NUM_ALT-1:0] alt_oe,
  output logic in_fwd,
  output logic nmi_fwd,
  // pad side
  input wire logic pad_in,
  output logic out,
  output logic oe,
  output logic pull_up,
  output logic slow_slew
);
  import pfs_pkg::*;

  logic [SEL_W-1:0] sel;
  logic listed;
  logic blocked;
  logic alt_o;
  logic alt_e;

  // code decode, unlisted codes pick nothing
  always_comb begin
    sel = cfg[F_SEL_LO +: SEL_W];
    listed = (sel <= SEL_FIFTH);
    alt_o = 1'b0;
    alt_e = 1'b0;
    if (listed) begin
      alt_o = alt_out[sel];
      alt_e = alt_oe[sel];
    end
  end

  // interrupt function and crystal use override the select field
  assign blocked = cfg[F_NMI] | xtal_on;
  assign out = blocked ? 1'b0 : alt_o;
  assign oe = ~blocked & cfg[F_OBE] & alt_e;
  // peripheral input admitted by buffer enable, interrupt input by its own bit, unless the pad is in crystal use
  assign in_fwd = cfg[F_IBE] & ~xtal_on & pad_in;
  assign nmi_fwd = cfg[F_NMI] & ~xtal_on & pad_in;
  assign pull_up = cfg[F_PUE] & ~xtal_on;
  // slow pads are always slow, others take the setting
  assign slow_slew = (PAD_KIND == PT_SLOW) | cfg[F_SLOW];
endmodule : pfs_pad_slice

/* File: design/pfs_pad_function_select.sv */
`timescale 1ns/1ps
// ==========================================================
// Functional notes
// - select code 000 routes first alternate, 001..011 next three, 100 the fifth
// - a pad input reaches periph_in and src_sel_in only with its buffer enable set, nmi_req without it
// - input-only functions ignore the select code, buffer enable alone decides
// - pad inputs fan out to all users; one user picks its pad by field
// - interrupt function on a pad overrides every alternate and the select code
// - crystal pads in oscillator use carry no other function
// - after reset all pads are general-purpose except the four test pads
// - after reset pads 0..3 carry test data in/out, clock and mode
// - self-test enabled: first trace pad driven high until reset ends
// - self-test disabled: first trace pad driven only by the trace enables
// - trace data 7..0, start/end and clock enabled by clock or status enable
// - trace data 8..11 need clock enable with full port, or status enable
// - medium and fast pads accept the slow slew setting
module pfs_pad_function_select (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic [pfs_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pfs_pkg::DATA_W-1:0] avs_writedata,
  output logic [pfs_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // peripheral functions
  input wire logic [pfs_pkg::NUM_PADS*pfs_pkg::NUM_ALT-1:0] alt_out,
  input wire logic [pfs_pkg::NUM_PADS*pfs_pkg::NUM_ALT-1:0] alt_oe,
  output logic [pfs_pkg::NUM_PADS-1:0] periph_in,
  output logic src_sel_in,
  output logic nmi_req,
  // pads
  input wire logic [pfs_pkg::NUM_PADS-1:0] pad_in,
  output logic [pfs_pkg::NUM_PADS-1:0] pad_out,
  output logic [pfs_pkg::NUM_PADS-1:0] pad_oe,
  output logic [pfs_pkg::NUM_PADS-1:0] pad_pull_up,
  output logic [pfs_pkg::NUM_PADS-1:0] pad_slow_slew,
  // oscillator and self-test
  input wire logic slow_xtal_en,
  input wire logic self_test_en,
  // debug port control and trace pads
  input wire logic trace_clock_out_enable,
  input wire logic processor_status_enable,
  input wire logic full_port_mode,
  input wire logic [pfs_pkg::TRACE_W-1:0] trace_src,
  output logic [pfs_pkg::TRACE_W-1:0] trace_out,
  output logic [pfs_pkg::TRACE_W-1:0] trace_oe
);
  import pfs_pkg::*;

  // ==========================================================
  // decode helpers
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    addr_hit = (a[ADDR_W-1:ADDR_IDX_LO] == ofs[ADDR_W-1:ADDR_IDX_LO]);
  endfunction : addr_hit

  function automatic logic pcr_hit(input logic [ADDR_W-1:0] a);
    pcr_hit = (a >= OFS_PCR_BASE) && (a < OFS_PCR_END);
  endfunction : pcr_hit

  // ==========================================================
  // state
  pfs_bus_st_t st_q;
  logic waitreq_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [NUM_PADS-1:0][CFG_W-1:0] pcr_q;
  logic [SEL_W-1:0] insel_q;
  logic [NUM_PADS-1:0] pad_s1_q;
  logic [NUM_PADS-1:0] pad_s2_q;
  logic self_test_controller_s1_q;
  logic self_test_controller_s2_q;
  logic memory_builtin_self_test_d;
  logic memory_builtin_self_test_q;
  logic wr_fire;
  logic [IDX_W-1:0] pcr_idx;
  logic [STATUS_W-1:0] status;
  logic [NUM_PADS-1:0] s_out;
  logic [NUM_PADS-1:0] s_oe;
  logic [NUM_PADS-1:0] s_pu;
  logic [NUM_PADS-1:0] s_slow;
  logic [NUM_PADS-1:0] s_in;
  logic [NUM_PADS-1:0] s_nmi;
  logic [NUM_PADS-1:0] periph_in_q;
  logic [NUM_PADS-1:0] pad_out_q;
  logic [NUM_PADS-1:0] pad_oe_q;
  logic [NUM_PADS-1:0] pad_pu_q;
  logic [NUM_PADS-1:0] pad_slow_q;
  logic src_in_q;
  logic nmi_q;
  logic en_low;
  logic en_high;
  logic [TRACE_W-1:0] trace_oe_d;
  logic [TRACE_W-1:0] trace_out_d;
  logic [TRACE_W-1:0] trace_oe_q;
  logic [TRACE_W-1:0] trace_out_q;

  // ==========================================================
  // bus slave: one wait cycle, write lands on the acknowledge edge
  assign pcr_idx = avs_address[ADDR_IDX_LO +: IDX_W];
  assign wr_fire = (st_q == ST_ACK) && avs_write;

  // read data mux
  always_comb begin
    rdata_d = '0;
    if (pcr_hit(avs_address)) begin
      rdata_d[CFG_W-1:0] = pcr_q[pcr_idx];
    end else if (addr_hit(avs_address, OFS_INSEL)) begin
      rdata_d[SEL_W-1:0] = insel_q;
    end else if (addr_hit(avs_address, OFS_STATUS)) begin
      rdata_d[STATUS_W-1:0] = status;
    end
  end

  // handshake state
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      waitreq_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (avs_read || avs_write) begin
            st_q <= ST_ACK;
            waitreq_q <= 1'b0;
            rdata_q <= avs_read ? rdata_d : '0;
          end
        end
        ST_ACK: begin
          st_q <= ST_IDLE;
          waitreq_q <= 1'b1;
        end
        default: begin
          st_q <= ST_IDLE;
          waitreq_q <= 1'b1;
        end
      endcase
    end
  end

  assign avs_waitrequest = waitreq_q;
  assign avs_readdata = rdata_q;

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk) begin
    if (srst) begin
      pcr_q <= CFG_RST;
    end else if (wr_fire && pcr_hit(avs_address)) begin
      pcr_q[pcr_idx] <= avs_writedata[CFG_W-1:0];
    end
  end

  // input source select for the shared peripheral input
  always_ff @(posedge clk) begin
    if (srst) begin
      insel_q <= INSEL_RST;
    end else if (wr_fire && addr_hit(avs_address, OFS_INSEL)) begin
      insel_q <= avs_writedata[SEL_W-1:0];
    end
  end

  // status view
  always_comb begin
    status = '0;
    status[S_MEMORY_BUILTIN_SELF_TEST] = memory_builtin_self_test_q;
    status[S_XTAL] = slow_xtal_en;
    status[S_TRACE_CLOCK_OUT] = trace_clock_out_enable;
    status[S_PSTAT] = processor_status_enable;
    status[S_FPM] = full_port_mode;
  end

  // ==========================================================
  // pad input synchronisers
  always_ff @(posedge clk) begin
    if (srst) begin
      pad_s1_q <= '0;
      pad_s2_q <= '0;
    end else begin
      pad_s1_q <= pad_in;
      pad_s2_q <= pad_s1_q;
    end
  end

  // ==========================================================
  // per-pad muxing
  for (genvar i = 0; i < NUM_PADS; i++) begin : g_pad
    pfs_pad_slice #(
      .PAD_KIND(PAD_TYPE[i])
    ) u_slice (
      .cfg(pcr_q[i]),
      .xtal_on(slow_xtal_en & XTAL_MASK[i]),
      .alt_out(alt_out[i*NUM_ALT +: NUM_ALT]),
      .alt_oe(alt_oe[i*NUM_ALT +: NUM_ALT]),
      .in_fwd(s_in[i]),
      .nmi_fwd(s_nmi[i]),
      .pad_in(pad_s2_q[i]),
      .out(s_out[i]),
      .oe(s_oe[i]),
      .pull_up(s_pu[i]),
      .slow_slew(s_slow[i])
    );
  end

  // registered pad and peripheral outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
      pad_pu_q <= '0;
      pad_slow_q <= '0;
      periph_in_q <= '0;
      src_in_q <= 1'b0;
      nmi_q <= 1'b0;
    end else begin
      pad_out_q <= s_out;
      pad_oe_q <= s_oe;
      pad_pu_q <= s_pu;
      pad_slow_q <= s_slow;
      periph_in_q <= s_in;
      src_in_q <= s_in[insel_q];
      nmi_q <= |s_nmi;
    end
  end

  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;
  assign pad_pull_up = pad_pu_q;
  assign pad_slow_slew = pad_slow_q;
  assign periph_in = periph_in_q;
  assign src_sel_in = src_in_q;
  assign nmi_req = nmi_q;

  // ==========================================================
  // self-test indication, strap caught while reset is high
  always_ff @(posedge clk) begin
    self_test_controller_s1_q <= self_test_en;
    self_test_controller_s2_q <= self_test_controller_s1_q;
  end

  assign memory_builtin_self_test_d = srst & self_test_controller_s2_q;

  always_ff @(posedge clk) begin
    memory_builtin_self_test_q <= memory_builtin_self_test_d;
  end

  // ==========================================================
  // trace pad enables from the debug port control
  assign en_low = trace_clock_out_enable | processor_status_enable;
  assign en_high = (trace_clock_out_enable & full_port_mode) | processor_status_enable;

  always_comb begin
    trace_oe_d = '0;
    trace_out_d = trace_src;
    // a debugger may claim the trace pads while reset is still high
    trace_oe_d[TRACE_LOW_W-1:0] = {TRACE_LOW_W{en_low}};
    trace_oe_d[TR_HI_LO +: TR_HI_W] = {TR_HI_W{en_high}};
    trace_oe_d[TR_TRACE_MESSAGE_START_END] = en_low;
    trace_oe_d[TR_TRACE_CLOCK_OUT] = en_low;
    if (memory_builtin_self_test_d) begin
      trace_oe_d[0] = 1'b1;
      trace_out_d[0] = 1'b1;
    end
  end

  // no reset branch: enables stay live through reset
  always_ff @(posedge clk) begin
    trace_oe_q <= trace_oe_d;
    trace_out_q <= trace_out_d;
  end

  assign trace_oe = trace_oe_q;
  assign trace_out = trace_out_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_bus_one_wait: assert property ((st_q == ST_IDLE) && (avs_read || avs_write)
      |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not low for exactly one cycle");

  a_cfg_after_reset: assert property ($fell(srst) |-> pcr_q == CFG_RST)
    else $error("pad config not at reset default");

  a_src_follows_sel: assert property (##1 src_in_q == periph_in_q[$past(insel_q)])
    else $error("selected source input mismatch");

  a_trace_low_en: assert property (en_low |=> (&trace_oe_q[TRACE_LOW_W-1:0])
      && trace_oe_q[TR_TRACE_MESSAGE_START_END] && trace_oe_q[TR_TRACE_CLOCK_OUT])
    else $error("low trace pads not enabled");

  a_trace_high_en: assert property ((|trace_oe_q[TR_HI_LO +: TR_HI_W])
      |-> $past(en_high))
    else $error("high trace pads enabled without cause");

  a_memory_builtin_self_test_drive: assert property ($past(srst) && $past(self_test_controller_s2_q)
      |-> trace_oe_q[0] && trace_out_q[0])
    else $error("self-test pad not driven high");

  a_memory_builtin_self_test_quiet: assert property ($past(srst) && !$past(self_test_controller_s2_q)
      |-> trace_oe_q[0] == $past(en_low))
    else $error("first trace pad driven without self-test");

  for (genvar k = 0; k < NUM_PADS; k++) begin : g_chk
    a_first_alt: assert property (!srst && (pcr_q[k][F_SEL_LO +: SEL_W] == SEL_FIRST)
        && !pcr_q[k][F_NMI] && !(slow_xtal_en && XTAL_MASK[k])
        |=> pad_out_q[k] == $past(alt_out[k*NUM_ALT]))
      else $error("first alternate not routed");

    a_in_needs_ibe: assert property (periph_in_q[k] |-> $past(pcr_q[k][F_IBE]))
      else $error("input passed without buffer enable");

    a_in_any_code: assert property (pcr_q[k][F_IBE] && pad_s2_q[k]
        && !(slow_xtal_en && XTAL_MASK[k]) |=> periph_in_q[k])
      else $error("enabled input not forwarded");

    a_nmi_no_out: assert property (pcr_q[k][F_NMI] |=> !pad_oe_q[k])
      else $error("pad driven while interrupt selected");

    a_xtal_quiet: assert property (slow_xtal_en && XTAL_MASK[k]
        |=> !pad_oe_q[k] && !pad_pu_q[k] && !periph_in_q[k])
      else $error("crystal pad carries another function");

    a_unlisted_off: assert property ((pcr_q[k][F_SEL_LO +: SEL_W] > SEL_FIFTH)
        |=> !pad_oe_q[k])
      else $error("unlisted code drives pad");

    if (PAD_TYPE[k] != PT_SLOW) begin : g_slew
      a_slew_taken: assert property (pcr_q[k][F_SLOW] |=> pad_slow_q[k])
        else $error("slow slew setting ignored");
    end
  end

  c_cfg_write: cover property (wr_fire && pcr_hit(avs_address));
  c_nmi_pad: cover property (nmi_q);
  c_full_trace: cover property (&trace_oe_q[TR_HI_LO +: TR_HI_W]);
  c_memory_builtin_self_test_seen: cover property ($past(memory_builtin_self_test_q) && !memory_builtin_self_test_q);
endmodule : pfs_pad_function_select

/* File: test/pfs_far_end.sv */
`timescale 1ns/1ps
// ==========================================================
// far side: peripherals behind the alternates and the board at the pads
module pfs_far_end (
  // controls from the bench
  input wire logic [pfs_pkg::NUM_PADS*pfs_pkg::NUM_ALT-1:0] alt_pat,
  input wire logic [pfs_pkg::NUM_PADS-1:0] ext_level,
  // peripheral side
  output logic [pfs_pkg::NUM_PADS*pfs_pkg::NUM_ALT-1:0] alt_out,
  output logic [pfs_pkg::NUM_PADS*pfs_pkg::NUM_ALT-1:0] alt_oe,
  // pad side
  input wire logic [pfs_pkg::NUM_PADS-1:0] pad_out,
  input wire logic [pfs_pkg::NUM_PADS-1:0] pad_oe,
  input wire logic [pfs_pkg::NUM_PADS-1:0] pad_pull_up,
  output logic [pfs_pkg::NUM_PADS-1:0] pad_in
);
  import pfs_pkg::*;
  // every peripheral always asks to drive, so only the mux decides
  assign alt_oe = '1;
  assign alt_out = alt_pat;
  // pad level: device drive wins, then pull-up, then the board level
  // trace pads are left alone, the board never pulls the self-test pad low
  always_comb begin
    for (int i = 0; i < NUM_PADS; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (pad_pull_up[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ext_level[i];
      end
    end
  end
endmodule : pfs_far_end

/* File: test/test_pad_function_select.sv */
`timescale 1ns/1ps
// ==========================================================
// bench for the pad function select block
module test_pad_function_select;
  import pfs_pkg::*;
  localparam int AW = NUM_PADS * NUM_ALT;
  localparam logic [DATA_W-1:0] IN_EN = 32'h8;
  localparam logic [DATA_W-1:0] OUT_EN = 32'h10;
  localparam logic [DATA_W-1:0] SLOW_EN = 32'h40;
  localparam logic [DATA_W-1:0] IRQ_EN = 32'h80;
  // clock, reset and bus
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  // pads and peripherals
  logic [AW-1:0] alt_pat = '0;
  logic [AW-1:0] alt_out;
  logic [AW-1:0] alt_oe;
  logic [NUM_PADS-1:0] ext_level = 8'hC0;
  logic [NUM_PADS-1:0] periph_in, pad_in, pad_out, pad_oe, pad_pull_up, pad_slow_slew;
  logic src_sel_in;
  logic nmi_req;
  // oscillator, self-test and trace
  logic slow_xtal_en = 1'b0;
  logic self_test_en = 1'b1;
  logic trace_clock_out_enable = 1'b0;
  logic processor_status_enable = 1'b0;
  logic full_port_mode = 1'b0;
  logic [TRACE_W-1:0] trace_src = '0;
  logic [TRACE_W-1:0] trace_out, trace_oe, exp_oe;
  logic lo, hi;
  logic [DATA_W-1:0] rd;
  int miscompares = 0;
  int samples_checked = 0;

  // clock generator
  always #5 clk = ~clk;

  pfs_pad_function_select dut (
    .clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .alt_out(alt_out), .alt_oe(alt_oe), .periph_in(periph_in),
    .src_sel_in(src_sel_in), .nmi_req(nmi_req),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_slow_slew(pad_slow_slew),
    .slow_xtal_en(slow_xtal_en), .self_test_en(self_test_en),
    .trace_clock_out_enable(trace_clock_out_enable),
    .processor_status_enable(processor_status_enable),
    .full_port_mode(full_port_mode), .trace_src(trace_src),
    .trace_out(trace_out), .trace_oe(trace_oe)
  );

  pfs_far_end far (
    .alt_pat(alt_pat), .ext_level(ext_level), .alt_out(alt_out), .alt_oe(alt_oe),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .pad_in(pad_in)
  );

  // comparisons
  task automatic chk_reg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                         input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s read %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s pins %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk_pin

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle

  // one bus access, held until waitrequest is sampled low
  task automatic bus_xfer(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus_xfer

  // reset with the self-test strap set as given
  task automatic do_reset(input logic ste);
    self_test_en <= ste;
    srst <= 1'b1;
    settle(10);
    chk_pin(16'(trace_oe[0]), 16'(ste), "self-test drive");
    chk_pin(16'(trace_out[0] & trace_oe[0]), 16'(ste), "self-test level");
    chk_pin(16'(pad_oe), 16'h0000, "reset tristate");
    settle(10);
    srst <= 1'b0;
    settle(1);
  endtask : do_reset

  task automatic test_done;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // watchdog
  initial begin
    settle(5000);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end

  // test sequence
  initial begin
    do_reset(1'b1);
    settle(2);
    chk_pin(16'(trace_oe), 16'h0000, "self-test released");
    for (int i = 0; i < NUM_PADS; i++) begin
      bus_xfer(1'b0, OFS_PCR_BASE + ADDR_W'(4 * i), '0);
      chk_reg(rd, DATA_W'(CFG_RST[i]), "reset config");
    end
    chk_pin(16'(pad_oe), 16'h0002, "reset drive");
    chk_pin(16'(pad_pull_up), 16'h0001, "reset pull");
    chk_pin(16'(pad_slow_slew), 16'h0070, "reset slew");
    bus_xfer(1'b0, 8'h30, '0);
    chk_reg(rd, 32'h0, "unmapped");
    // every select code on pad 7, routed and inverted
    for (int k = 0; k < 8; k++) begin
      bus_xfer(1'b1, 8'h1C, DATA_W'(k) | OUT_EN);
      alt_pat <= AW'(1) << (7 * NUM_ALT + k);
      settle(2);
      chk_pin(16'(pad_oe[7]), 16'(k < NUM_ALT), "select drive");
      chk_pin(16'(pad_out[7] & pad_oe[7]), 16'(k < NUM_ALT), "select route");
      alt_pat <= ~(AW'(1) << (7 * NUM_ALT + k));
      settle(2);
      chk_pin(16'(pad_out[7] & pad_oe[7]), 16'h0000, "select inverse");
    end
    bus_xfer(1'b1, 8'h1C, SLOW_EN);
    settle(2);
    chk_pin(16'(pad_slow_slew), 16'h00F0, "slow slew");
    // interrupt function overrides output and select
    alt_pat <= '1;
    bus_xfer(1'b1, 8'h1C, IRQ_EN | OUT_EN | IN_EN);
    settle(5);
    chk_pin(16'(pad_oe[7]), 16'h0000, "interrupt blocks drive");
    chk_pin(16'(nmi_req), 16'h0001, "interrupt high");
    ext_level <= 8'h40;
    settle(5);
    chk_pin(16'(nmi_req), 16'h0000, "interrupt low");
    // input gating on pad 6 and source select
    bus_xfer(1'b1, 8'h18, 32'h0);
    settle(5);
    chk_pin(16'(periph_in[6]), 16'h0000, "input gated");
    bus_xfer(1'b1, 8'h18, IN_EN | 32'h5);
    settle(5);
    chk_pin(16'(periph_in[6]), 16'h0001, "input passed");
    bus_xfer(1'b1, OFS_INSEL, 32'h6);
    bus_xfer(1'b0, OFS_INSEL, '0);
    chk_reg(rd, 32'h6, "source select");
    settle(3);
    chk_pin(16'(src_sel_in), 16'h0001, "source pad 6");
    bus_xfer(1'b1, OFS_INSEL, 32'h3);
    settle(3);
    chk_pin(16'(src_sel_in), 16'h0000, "source pad 3");
    // crystal pads: crystal use blocks the input despite input enable
    slow_xtal_en <= 1'b1;
    ext_level <= 8'h70;
    bus_xfer(1'b1, 8'h10, IN_EN);
    settle(5);
    chk_pin(16'(periph_in[4]), 16'h0000, "crystal blocks input");
    bus_xfer(1'b1, OFS_STATUS, 32'h1F);
    bus_xfer(1'b0, OFS_STATUS, '0);
    chk_reg(rd, 32'h2, "status crystal");
    slow_xtal_en <= 1'b0;
    settle(5);
    chk_pin(16'(periph_in[4]), 16'h0001, "crystal released");
    // trace enables over all combinations
    trace_src <= '1;
    for (int m = 0; m < 8; m++) begin
      trace_clock_out_enable <= m[2];
      processor_status_enable <= m[1];
      full_port_mode <= m[0];
      settle(2);
      lo = m[2] | m[1];
      hi = (m[2] & m[0]) | m[1];
      exp_oe = {lo, lo, {4{hi}}, {8{lo}}};
      chk_pin(16'(trace_oe), 16'(exp_oe), "trace enable");
      chk_pin(16'(trace_out & trace_oe), 16'(exp_oe), "trace data");
    end
    trace_clock_out_enable <= 1'b0;
    processor_status_enable <= 1'b0;
    full_port_mode <= 1'b0;
    do_reset(1'b0);
    test_done();
  end
endmodule : test_pad_function_select
